// ### logic/gsp_pkg.sv
// constants for the gated serial-in parallel-out shifter
// assumes a single clock and an active-low asynchronous clear
package gsp_pkg;
   // ************************************
   // widths and counts
   // ************************************
   localparam int STAGES = 8;
   localparam int CNT_W = 3;
   localparam int BUF_DEPTH = 2;
   typedef logic [STAGES-1:0] gsp_word_t;
   typedef logic [CNT_W-1:0] gsp_cnt_t;
   // ************************************
   // reset and terminal values
   // ************************************
   localparam gsp_word_t STAGE_RESET = 8'h00;
   localparam gsp_cnt_t CNT_RESET = 3'h0;
   localparam gsp_cnt_t CNT_LAST = 3'h7;
endpackage : gsp_pkg

// ### logic/gsp_buf_if.sv
// carrier between the shifter and its two-entry word buffer
// assumes both ends share clk and rst_n
`timescale 1ns/1ps
interface gsp_buf_if;
   logic push_valid;
   logic push_ready;
   gsp_pkg::gsp_word_t push_data;
   logic pop_valid;
   logic pop_ready;
   gsp_pkg::gsp_word_t pop_data;
   modport fill (output push_valid, output push_data, input push_ready,
                 input pop_valid, input pop_data, output pop_ready);
   modport store (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
endinterface : gsp_buf_if

// ### logic/gsp_word_buf.sv
// two-entry word buffer, head entry always in slot 0
// assumes push and pop from the same clock domain
`timescale 1ns/1ps
module gsp_word_buf (
   input wire logic clk,
   input wire logic rst_n,
   gsp_buf_if.store bus
);
   gsp_pkg::gsp_word_t slot0;
   gsp_pkg::gsp_word_t slot1;
   logic full0;
   logic full1;
   logic room;
   wire pop = full0 && bus.pop_ready;
   wire push = bus.push_valid && !full1;
   wire next_full0 = push || full1 || (full0 && !pop);
   wire next_full1 = (full1 && !pop) || (push && full0 && !pop);
   // ************************************
   // outputs straight from slot and room flops
   // ************************************
   assign bus.pop_valid = full0;
   assign bus.pop_data = slot0;
   assign bus.push_ready = room;
   // slot valids move on push and pop; room is a flop of its own
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full0 <= 1'b0;
         full1 <= 1'b0;
         room <= 1'b1;
      end else begin
         full0 <= next_full0;
         full1 <= next_full1;
         room <= !next_full1;
      end
   end
   // slot data: head refills from slot1 or the new word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot0 <= gsp_pkg::STAGE_RESET;
         slot1 <= gsp_pkg::STAGE_RESET;
      end else begin
         if (pop || !full0) begin
            slot0 <= full1 ? slot1 : bus.push_data;
         end
         if (push && (full1 || (full0 && !pop))) begin
            slot1 <= bus.push_data;
         end
      end
   end
endmodule : gsp_word_buf

// ### logic/gsp_shifter.sv
// eight-stage gated serial-in parallel-out shift register with word buffer
// assumes serial inputs synchronous to clk; clear is rst_n, asynchronous
//
// Operation
// - Eight chained stages each show their content on a parallel output at all times.
// - A low on either serial input loads a low into the first stage at the clock edge.
// - With one serial input high the other alone sets the entering bit, their AND.
// - Apart from the clear, stages change only on the rising clock edge.
// - The active-low clear forces all stages low at once, regardless of clock and data.
// - Without clear and without a rising edge every stage holds its level.
// - Each rising edge moves every stage one place, stage n taking stage n-1.
`timescale 1ns/1ps
module gsp_shifter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_a,
   input wire logic serial_b,
   output logic [7:0] stage_q,
   output logic first_stage_output,
   output logic last_stage_output,
   output logic word_ready,
   output logic word_valid,
   output logic [7:0] word_data,
   input wire logic word_take,
   output logic word_lost
);
   // ************************************
   // declarations
   // ************************************

   // one flop per stage, index 0 is the first stage
   logic chain [gsp_pkg::STAGES];

   // the chain packed into a word, bit 0 first
   wire gsp_pkg::gsp_word_t stage;

   // level each stage takes at the coming rising edge
   wire gsp_pkg::gsp_word_t next_stage;

   // bits shifted since clear, modulo one word
   gsp_pkg::gsp_cnt_t bit_cnt;

   // counter value after the coming rising edge
   wire gsp_pkg::gsp_cnt_t next_bit_cnt;

   // gated pair, the bit that enters the first stage
   wire entry_bit;

   // high on the edge that completes a word
   wire word_done;

   // high when a completed word finds no room
   wire word_drop;

   // drop flag after the coming edge
   wire next_word_lost;

   // carrier to the two-entry word buffer
   gsp_buf_if buf_bus ();

   // ************************************
   // decoding helpers
   // ************************************

   // entering bit: a low on either input wins
   function automatic logic gsp_gate(input logic in_a, input logic in_b);
      gsp_gate = in_a & in_b;
   endfunction : gsp_gate

   // true on the count that closes a word
   function automatic logic gsp_is_last(input gsp_pkg::gsp_cnt_t cnt);
      gsp_is_last = (cnt == gsp_pkg::CNT_LAST);
   endfunction : gsp_is_last

   // last stage of a packed word
   function automatic logic gsp_tail(input gsp_pkg::gsp_word_t word);
      gsp_tail = word[gsp_pkg::STAGES-1];
   endfunction : gsp_tail

   // ************************************
   // entry gating
   // ************************************

   // a low on either serial input loads a low
   assign entry_bit = gsp_gate(serial_a, serial_b);

   // the first stage takes the gated bit
   assign next_stage[0] = entry_bit;

   // ************************************
   // chain wiring
   // ************************************

   // every later stage takes the stage before it
   generate
      for (genvar i = 1; i < gsp_pkg::STAGES; i++) begin : g_link
         assign next_stage[i] = chain[i-1];
      end
   endgenerate

   // packed view of the chain
   generate
      for (genvar j = 0; j < gsp_pkg::STAGES; j++) begin : g_pack
         assign stage[j] = chain[j];
      end
   endgenerate

   // ************************************
   // stage flops
   // ************************************

   // each stage clears at once, otherwise moves only on a rising edge
   generate
      for (genvar k = 0; k < gsp_pkg::STAGES; k++) begin : g_stage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               chain[k] <= gsp_pkg::STAGE_RESET[k];
            end else begin
               chain[k] <= next_stage[k];
            end
         end
      end
   endgenerate

   // ************************************
   // parallel outputs
   // ************************************

   // output flops mirror the stages, no load or enable path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_q <= gsp_pkg::STAGE_RESET;
      end else begin
         stage_q <= next_stage;
      end
   end

   // first stage on its own pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_stage_output <= gsp_pkg::STAGE_RESET[0];
      end else begin
         first_stage_output <= next_stage[0];
      end
   end

   // last stage on its own pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_stage_output <= gsp_pkg::STAGE_RESET[gsp_pkg::STAGES-1];
      end else begin
         last_stage_output <= gsp_tail(next_stage);
      end
   end

   // ************************************
   // word framing
   // ************************************

   // counter wraps every eight shifts
   assign next_bit_cnt = gsp_pkg::gsp_cnt_t'(bit_cnt + 3'h1);

   // a word closes on the eighth shift
   assign word_done = gsp_is_last(bit_cnt);

   // bit counter, never stalls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= gsp_pkg::CNT_RESET;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   // ************************************
   // word buffer
   // ************************************

   // completed word offered with the shift that closes it
   assign buf_bus.push_valid = word_done;

   // the word as it stands after that shift
   assign buf_bus.push_data = next_stage;

   // consumer strobe pops the head word
   assign buf_bus.pop_ready = word_take;

   // two slots so a stalled consumer loses no word until a third closes
   gsp_word_buf u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .bus(buf_bus.store)
   );

   // head valid, straight from the buffer flop
   assign word_valid = buf_bus.pop_valid;

   // head word, straight from slot 0
   assign word_data = buf_bus.pop_data;

   // room flag, straight from the buffer flop
   assign word_ready = buf_bus.push_ready;

   // ************************************
   // lost word flag
   // ************************************

   // a closing word with no room is dropped
   assign word_drop = word_done && !buf_bus.push_ready;

   // flag only sets; clear is its sole release
   assign next_word_lost = word_lost || word_drop;

   // sticky drop flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_lost <= 1'b0;
      end else begin
         word_lost <= next_word_lost;
      end
   end
endmodule : gsp_shifter

// ### verif/gsp_sva.sv
// checker on the shifter ports
// assumes rst_n is the asynchronous clear
`timescale 1ns/1ps
module gsp_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_a,
   input wire logic serial_b,
   input wire logic [7:0] stage_q,
   input wire logic first_stage_output,
   input wire logic last_stage_output,
   input wire logic word_lost
);
   logic [7:0] q_neg;
   // stages as seen at the falling edge
   always_ff @(negedge clk) q_neg <= stage_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // outputs, gating, shifting and clear
   property p_q0; first_stage_output == stage_q[0]; endproperty
   a_q0: assert property (p_q0) else $error("q0 bad");
   property p_q7; last_stage_output == stage_q[7]; endproperty
   a_q7: assert property (p_q7) else $error("q7 bad");
   property p_low; !(serial_a && serial_b) |=> !stage_q[0]; endproperty
   a_low: assert property (p_low) else $error("low bad");
   property p_pass; serial_a |=> stage_q[0] == $past(serial_b); endproperty
   a_pass: assert property (p_pass) else $error("pass bad");
   property p_shift; 1 |=> stage_q[7:1] == $past(stage_q[6:0]); endproperty
   a_shift: assert property (p_shift) else $error("shift bad");
   property p_hold; $past(rst_n) |-> stage_q == q_neg; endproperty
   a_hold: assert property (p_hold) else $error("hold bad");
   property p_only; 1 |=> stage_q == {$past(stage_q[6:0]), $past(serial_a & serial_b)}; endproperty
   a_only: assert property (p_only) else $error("load bad");
   property p_clr; @(posedge clk) disable iff (1'b0) !rst_n |=> stage_q == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("clear bad");
   // lost flag stays up once set
   sequence s_lost; word_lost; endsequence
   property p_lost; s_lost |=> word_lost; endproperty
   a_lost: assert property (p_lost) else $error("lost flag dropped");
endmodule : gsp_sva
bind gsp_shifter gsp_sva sva_u (.clk, .rst_n, .serial_a, .serial_b, .stage_q,
   .first_stage_output, .last_stage_output, .word_lost);

// ### verif/gsp_src.sv
// source model for the two serial inputs, oldest bit first
// assumes the shifter samples on the rising edge
`timescale 1ns/1ps
module gsp_src (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] pat_a,
   input wire logic [7:0] pat_b,
   output logic serial_a,
   output logic serial_b
);
   logic [2:0] idx = 3'h0;
   // index moves at the falling edge, bits steady at the rising one
   always @(negedge clk) idx <= rst_n ? idx + 3'h1 : 3'h0;
   assign serial_a = pat_a[3'h7 - idx];
   assign serial_b = pat_b[3'h7 - idx];
endmodule : gsp_src

// ### verif/gsp_shifter_bench.sv
// bench: fill, overflow, drain and clear of the shifter
// assumes the source model and the bound checker
`timescale 1ns/1ps
module gsp_shifter_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic word_take = 1'b0;
   logic serial_a, serial_b, word_ready, word_valid, word_lost;
   logic [7:0] stage_q, word_data;
   int failures = 0;
   int num_checks = 0;
   always #2 clk = ~clk;
   gsp_src src_u (.clk, .rst_n, .pat_a(8'hB5), .pat_b(8'hEF), .serial_a, .serial_b);
   gsp_shifter dut_u (.clk, .rst_n, .serial_a, .serial_b, .stage_q, .first_stage_output(),
      .last_stage_output(), .word_ready, .word_valid, .word_data, .word_take, .word_lost);
   // compare and verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   // eight bits in, buffer overflows, then drained
   task automatic t_fill();
      repeat (8) @(negedge clk);
      chk(stage_q, 8'hA5);
      chk(word_data, 8'hA5);
      repeat (16) @(negedge clk);
      chk({6'h00, word_ready, word_lost}, 8'h01);
      word_take <= 1'b1;
      repeat (2) @(negedge clk);
      word_take <= 1'b0;
      chk({6'h00, word_ready, word_valid}, 8'h02);
      $display("fill done");
   endtask : t_fill
   // clear in mid-run acts without a clock edge
   task automatic t_clear();
      rst_n <= 1'b0;
      #1;
      chk(stage_q, 8'h00);
      $display("clear done");
   endtask : t_clear
   initial begin
      repeat (8) @(negedge clk);
      rst_n <= 1'b1;
      t_fill();
      t_clear();
      final_report();
   end
endmodule : gsp_shifter_bench
